/* hdl/scc_clock_control.v */
`include "scc_consts.vh"
`default_nettype none
// Internal oscillator modelled as a divider of CLOCK issuing tick pulses;
// the external oscillator arrives as synchronous edge pulses.
module scc_clock_control
#(
    parameter SETTLE_CYC = `SCC_SETTLE_CYC,
    parameter MISS_CYC = `SCC_MISS_CYC
)
(
    input wire CLOCK,
    input wire RST,
    input wire RST_PIN_N,
    input wire SFR_WR,
    input wire SFR_RD,
    input wire [7:0] SFR_ADDR,
    input wire [7:0] SFR_WDATA,
    input wire EXT_OSC_TICK,
    output reg [7:0] SFR_RDATA,
    output reg SYSCLK_TICK,
    output reg SYSCLK_IS_EXT,
    output reg INT_OSC_RUNNING,
    output reg EXT_DRIVE_EN,
    output reg MCD_RESET
);
    // Stored control fields; bits 6-5 have no flop behind them
    reg mcd_en_q;
    reg src_sel_q;
    reg osc_en_q;
    reg [1:0] freq_sel_q;
    reg ready_q;
    reg [15:0] settle_q;
    // Oscillator model and watch counters
    reg [3:0] div_q;
    reg int_tick_q;
    reg [15:0] miss_q;
    // Decode and qualifier nets
    wire any_rst;
    wire stop;
    wire mux_tick;
    wire mux_b;
    wire hit;
    wire wr_ctrl;
    wire rd_ctrl;
    wire retune;
    wire [7:0] ctrl_view;

    // Divide-by count for the selected internal speed (2/4/8/16 MHz steps).
    // The ratios keep the 1:2:4:8 spacing, scaled down to CLOCK.
    function [3:0] scc_div_limit;
        input [1:0] f;
        begin
            case (f)
                2'b00: scc_div_limit = 4'hF;
                2'b01: scc_div_limit = 4'h7;
                2'b10: scc_div_limit = 4'h3;
                default: scc_div_limit = 4'h1;
            endcase
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Register decode; only the control byte lives here, any other
    // address belongs to the rest of the register space and reads 0
    assign hit = (SFR_ADDR == `SCC_ADDR_CONTROL);
    assign wr_ctrl = SFR_WR & hit;
    assign rd_ctrl = SFR_RD & hit;
    assign any_rst = RST | ~RST_PIN_N | MCD_RESET;
    assign stop = ~RST_PIN_N;

    // Retune restarts settling
    // A write that changes the speed or drops the enable clears the flag
    // at the same edge as the fields change, never one edge later
    assign retune = wr_ctrl &
                    ((SFR_WDATA[1:0] != freq_sel_q) |
                     ~SFR_WDATA[`SCC_BIT_OSC_EN]);

    // Unused read zero
    // Read image of the control byte; bit 4 is live status
    assign ctrl_view = {mcd_en_q, 2'b00, ready_q, src_sel_q, osc_en_q,
                        freq_sel_q};

    ////////////////////////////////////////////////////////////////////////
    // Control register; reserved bits never stored. The pin and the
    // detector reset it as well, so with the detector enabled a lost
    // crystal falls back to the internal oscillator.
    always @(posedge CLOCK)
    begin
        if (any_rst)
        begin
            mcd_en_q <= 1'b0;
            src_sel_q <= 1'b0;
            osc_en_q <= 1'b1;
            freq_sel_q <= 2'b00;
        end
        else if (wr_ctrl)
        begin
            mcd_en_q <= SFR_WDATA[`SCC_BIT_MCD_EN];
            src_sel_q <= SFR_WDATA[`SCC_BIT_SRC_SEL];
            osc_en_q <= SFR_WDATA[`SCC_BIT_OSC_EN];
            freq_sel_q <= SFR_WDATA[1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Internal oscillator: divider runs only while enabled and not held.
    // The divider restarts from zero, so the first tick after an enable
    // comes one full period later, never a short one.
    always @(posedge CLOCK)
    begin
        if (RST || stop || !osc_en_q)
        begin
            div_q <= 4'h0;
            int_tick_q <= 1'b0;
        end
        else if (div_q >= scc_div_limit(freq_sel_q))
        begin
            div_q <= 4'h0;
            int_tick_q <= 1'b1;
        end
        else
        begin
            div_q <= div_q + 4'h1;
            int_tick_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Ready flag drops on any enable or frequency change and on restart.
    // Every reset source clears the settle count, so settling starts over
    // after the pin and after the detector as well.
    always @(posedge CLOCK)
    begin
        if (any_rst || !osc_en_q || retune)
        begin
            settle_q <= 16'h0;
            ready_q <= 1'b0;
        end
        else if (settle_q >= SETTLE_CYC[15:0] - 16'h1)
            ready_q <= 1'b1;
        else
            settle_q <= settle_q + 16'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // A source switch waits for one tick of the old and one of the new
    // source; a dead target source therefore leaves no clock at all.
    // Source select
    scc_glitch_free_mux u_mux
    (
        .clk(CLOCK),
        .rst(any_rst),
        .sel(src_sel_q),
        .tick_a(int_tick_q),
        .tick_b(EXT_OSC_TICK & ~stop),
        .tick_out(mux_tick),
        .active_b(mux_b)
    );

    ////////////////////////////////////////////////////////////////////////
    // Missing clock watch on the delivered clock; only when enabled.
    // The watch sees the muxed tick, so the quiet gap of a source switch
    // counts too; MISS_CYC must cover one period of each source.
    // The pulse clears itself and resets the control register.
    always @(posedge CLOCK)
    begin
        if (RST || stop || MCD_RESET || !mcd_en_q || mux_tick)
        begin
            miss_q <= 16'h0;
            MCD_RESET <= 1'b0;
        end
        else if (miss_q >= MISS_CYC[15:0] - 16'h1)
            MCD_RESET <= 1'b1;
        else
            miss_q <= miss_q + 16'h1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Delivered clock and its source, one flop after the mux
    always @(posedge CLOCK)
    begin
        if (RST)
        begin
            SYSCLK_TICK <= 1'b0;
            SYSCLK_IS_EXT <= 1'b0;
        end
        else
        begin
            SYSCLK_TICK <= mux_tick;
            SYSCLK_IS_EXT <= mux_b;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Oscillator run states; the pin holds both off at the next edge
    always @(posedge CLOCK)
    begin
        if (RST)
        begin
            INT_OSC_RUNNING <= 1'b0;
            EXT_DRIVE_EN <= 1'b0;
        end
        else
        begin
            INT_OSC_RUNNING <= osc_en_q & ~stop;
            EXT_DRIVE_EN <= ~stop;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Read data stands one cycle after the strobe, zero otherwise
    always @(posedge CLOCK)
    begin
        if (RST)
            SFR_RDATA <= 8'h00;
        else if (rd_ctrl)
            SFR_RDATA <= ctrl_view;
        else
            SFR_RDATA <= 8'h00;
    end
endmodule // scc_clock_control
`default_nettype wire

/* hdl/scc_consts.vh */
`ifndef SCC_CONSTS_VH
`define SCC_CONSTS_VH
`define SCC_ADDR_CONTROL 8'hB2
`define SCC_CONTROL_RESET 8'h04
`define SCC_BIT_MCD_EN 7
`define SCC_BIT_FREQ_READY 4
`define SCC_BIT_SRC_SEL 3
`define SCC_BIT_OSC_EN 2
`define SCC_WRITE_MASK 8'h8F
`define SCC_CLK_NS 4
// Time for the internal oscillator to settle after enable or retune, in ns
`define SCC_SETTLE_NS 1000
`define SCC_SETTLE_CYC ((`SCC_SETTLE_NS + `SCC_CLK_NS - 1) / `SCC_CLK_NS)
// Longest gap without an edge of the chosen source before reset, in ns
`define SCC_MISS_NS 400
`define SCC_MISS_CYC (`SCC_MISS_NS / `SCC_CLK_NS)
`endif

/* hdl/scc_glitch_free_mux.v */
`default_nettype none
// Switches between two enable streams; the old source is stopped at its
// own tick before the new one is allowed, so no phase is cut short.
module scc_glitch_free_mux
(
    input wire clk,
    input wire rst,
    input wire sel,
    input wire tick_a,
    input wire tick_b,
    output reg tick_out,
    output reg active_b
);
    reg own_a_q;
    reg own_b_q;

    ////////////////////////////////////////////////////////////////////////
    // Break before make
    always @(posedge clk)
    begin
        if (rst)
        begin
            own_a_q <= 1'b1;
            own_b_q <= 1'b0;
            tick_out <= 1'b0;
            active_b <= 1'b0;
        end
        else
        begin
            // Release only on a tick so the current phase completes
            if (own_a_q && sel && tick_a)
                own_a_q <= 1'b0;
            else if (!own_a_q && !own_b_q && !sel && tick_a)
                own_a_q <= 1'b1;
            if (own_b_q && !sel && tick_b)
                own_b_q <= 1'b0;
            else if (!own_a_q && !own_b_q && sel && tick_b)
                own_b_q <= 1'b1;
            tick_out <= (own_a_q & tick_a) | (own_b_q & tick_b);
            active_b <= own_b_q;
        end
    end
endmodule // scc_glitch_free_mux
`default_nettype wire

/* tb/scc_ext_osc.sv */
`default_nettype none
module scc_ext_osc
(
    input wire logic clk,
    input wire logic drive_en,
    input wire logic [4:0] period,
    output logic tick
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [4:0] n_q;
    // Ticks only while driven; period 0 stands for a dead crystal
    always @(posedge clk)
    begin
        n_q <= (drive_en && n_q + 5'h01 < period) ? n_q + 5'h01 : 5'h00;
        tick <= drive_en && period != 5'h00 && n_q == 5'h00;
    end
endmodule // scc_ext_osc
`default_nettype wire

/* tb/scc_clock_control_assertions.sv */
`default_nettype none
module scc_clock_control_assertions
#(
    parameter SETTLE_CYC = 8,
    parameter MISS_CYC = 40
)
(
    input wire logic CLOCK,
    input wire logic RST,
    input wire logic RST_PIN_N,
    input wire logic SFR_RD,
    input wire logic [7:0] SFR_ADDR,
    input wire logic [7:0] SFR_RDATA,
    input wire logic SYSCLK_IS_EXT,
    input wire logic INT_OSC_RUNNING,
    input wire logic EXT_DRIVE_EN,
    input wire logic MCD_RESET
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);
    sequence s_rd;
        SFR_RD && SFR_ADDR == 8'hB2;
    endsequence
    a_boot_int: assert property ($fell(RST) |-> !SYSCLK_IS_EXT)
        else $error("boot source");
    a_mcd_boot: assert property (
        MCD_RESET |-> ##[1:3] !SYSCLK_IS_EXT) else $error("mcd source");
    a_pin_stop: assert property (!RST_PIN_N |=>
        !INT_OSC_RUNNING && !EXT_DRIVE_EN) else $error("pin stop");
    a_mcd_pulse: assert property (MCD_RESET |=> !MCD_RESET)
        else $error("mcd pulse");
    a_rd_unused: assert property (
        s_rd |=> SFR_RDATA[6:5] == 2'h0) else $error("unused bits");
    a_ready_run: assert property (
        s_rd ##1 SFR_RDATA[4] |-> INT_OSC_RUNNING) else $error("ready flag");
    a_osc_off: assert property (s_rd ##1 !SFR_RDATA[2] |=>
        !INT_OSC_RUNNING) else $error("osc enable");
    a_sel_int: assert property (s_rd ##1 !SFR_RDATA[3] |->
        ##[0:60] !SYSCLK_IS_EXT) else $error("source select");
endmodule // scc_clock_control_assertions
bind scc_clock_control scc_clock_control_assertions
    #(.SETTLE_CYC(SETTLE_CYC), .MISS_CYC(MISS_CYC)) chk_i
(
    .CLOCK(CLOCK),
    .RST(RST),
    .RST_PIN_N(RST_PIN_N),
    .SFR_RD(SFR_RD),
    .SFR_ADDR(SFR_ADDR),
    .SFR_RDATA(SFR_RDATA),
    .SYSCLK_IS_EXT(SYSCLK_IS_EXT),
    .INT_OSC_RUNNING(INT_OSC_RUNNING),
    .EXT_DRIVE_EN(EXT_DRIVE_EN),
    .MCD_RESET(MCD_RESET)
);
`default_nettype wire

/* tb/tb.sv */
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic CLOCK = 1'h0, RST = 1'h1, RST_PIN_N = 1'h1, SFR_WR = 1'h0;
    logic SFR_RD = 1'h0, EXT_OSC_TICK, SYSCLK_TICK, SYSCLK_IS_EXT;
    logic INT_OSC_RUNNING, EXT_DRIVE_EN, MCD_RESET;
    logic [7:0] SFR_ADDR = 8'hB2, SFR_WDATA = 8'h00, SFR_RDATA;
    logic [4:0] per = 5'h03;
    wire logic [1:0] fl = {MCD_RESET, SYSCLK_IS_EXT};
    int n_fail = 0, n_tests = 0, cyc = 0;
    scc_clock_control #(.SETTLE_CYC(8), .MISS_CYC(40)) scc_clock_control_i
    (
        .CLOCK(CLOCK),
        .RST(RST),
        .RST_PIN_N(RST_PIN_N),
        .SFR_WR(SFR_WR),
        .SFR_RD(SFR_RD),
        .SFR_ADDR(SFR_ADDR),
        .SFR_WDATA(SFR_WDATA),
        .EXT_OSC_TICK(EXT_OSC_TICK),
        .SFR_RDATA(SFR_RDATA),
        .SYSCLK_TICK(SYSCLK_TICK),
        .SYSCLK_IS_EXT(SYSCLK_IS_EXT),
        .INT_OSC_RUNNING(INT_OSC_RUNNING),
        .EXT_DRIVE_EN(EXT_DRIVE_EN),
        .MCD_RESET(MCD_RESET)
    );
    scc_ext_osc scc_ext_osc_i (.clk(CLOCK), .drive_en(EXT_DRIVE_EN),
        .period(per), .tick(EXT_OSC_TICK));
    initial forever #2 CLOCK = ~CLOCK;
    // Hang guard; the run needs well under 2000 cycles
    always @(posedge CLOCK)
    begin
        cyc <= cyc + 1;
        if (cyc == 4000)
        begin
            n_fail++;
            give_verdict;
        end
    end
    task automatic give_verdict;
        if (n_fail == 0 && n_tests > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [7:0] g, e);
        n_tests++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error %0t: got %h want %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [7:0] d);
        @(negedge CLOCK) {SFR_WR, SFR_WDATA} = {1'h1, d};
        @(negedge CLOCK) SFR_WR = 1'h0;
    endtask
    task automatic rd(input logic [7:0] a, e);
        @(negedge CLOCK) {SFR_RD, SFR_ADDR} = {1'h1, a};
        @(negedge CLOCK) chk(SFR_RDATA, e);
        {SFR_RD, SFR_ADDR} = {1'h0, 8'hB2};
    endtask
    // Bounded wait on a flag, then compare it
    task automatic wfor(input int b, input logic v, e);
        for (int i = 0; i < 99 && fl[b] !== v; i++)
            @(negedge CLOCK);
        chk(8'(fl[b]), 8'(e));
    endtask
    // Delivered ticks over 32 falling edges; speeds scale 2:4:8:16
    task automatic cnt_tick(input logic [7:0] e);
        logic [7:0] n;
        n = 8'h00;
        repeat (32)
        begin
            @(negedge CLOCK);
            n = n + 8'(SYSCLK_TICK);
        end
        chk(n, e);
    endtask
    task automatic t_freq;
        for (int f = 3; f >= 0; f--)
        begin
            wr(8'h74 | 8'(f));
            rd(8'hB2, 8'h04 | 8'(f));
            repeat (20) @(negedge CLOCK);
            rd(8'hB2, 8'h14 | 8'(f));
            cnt_tick(8'h02 << f);
        end
        wr(8'h00);
        rd(8'hB2, 8'h00);
        chk(8'(INT_OSC_RUNNING), 8'h00);
        cnt_tick(8'h00);
        wr(8'h04);
        repeat (20) @(negedge CLOCK);
        rd(8'hB2, 8'h14);
    endtask
    task automatic t_sw;
        per = 5'h14;
        wr(8'h0C);
        wfor(0, 1'h1, 1'h1);
        rd(8'hB2, 8'h1C);
        wr(8'h04);
        wfor(0, 1'h0, 1'h0);
    endtask
    // Dead crystal with the detector on, then off
    task automatic t_mcd;
        per = 5'h03;
        wr(8'h8C);
        wfor(0, 1'h1, 1'h1);
        per = 5'h00;
        wfor(1, 1'h1, 1'h1);
        repeat (20) @(negedge CLOCK);
        rd(8'hB2, 8'h14);
        per = 5'h03;
        wr(8'h0C);
        wfor(0, 1'h1, 1'h1);
        per = 5'h00;
        wfor(1, 1'h1, 1'h0);
    endtask
    // Only the pin can rescue a dead external clock here
    task automatic t_pin;
        RST_PIN_N = 1'h0;
        repeat (3) @(negedge CLOCK);
        chk({6'h00, INT_OSC_RUNNING, EXT_DRIVE_EN}, 8'h00);
        RST_PIN_N = 1'h1;
        per = 5'h03;
        rd(8'hB2, 8'h04);
    endtask
    initial
    begin
        repeat (4) @(negedge CLOCK);
        RST = 1'h0;
        rd(8'hB3, 8'h00);
        rd(8'hB2, 8'h04);
        t_freq;
        t_sw;
        t_mcd;
        t_pin;
        give_verdict;
    end
endmodule // tb
`default_nettype wire
